// *** design/clhi_top.sv ***
`default_nettype none
module clhi_top
  import clhi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_e,
  input wire logic i_reg_select,
  input wire logic i_rw,
  input wire logic [7:0] i_db,
  input wire logic i_intf_strap_hi,
  input wire logic i_intf_strap_lo,
  output logic [7:0] o_db,
  output logic [7:0] o_db_oe,
  output logic o_busy_indicator,
  output logic [6:0] o_addr_counter,
  output logic o_glyph_sel,
  output logic o_entry_inc,
  output logic o_bus_8bit,
  output logic o_two_line
);
  // ==========================================================
  // Pin synchronisers
  logic [12:0] sync1_ff, nxt_sync1;  // First stage
  logic [12:0] sync2_ff, nxt_sync2;  // Second stage
  logic e_s, sel_s, rw_s;  // Synchronised strobe, select, direction
  logic [7:0] db_s;  // Synchronised data pins
  clhi_mode_t mode;  // Selected host interface

  // Two-stage capture of every pin
  always_comb begin
    nxt_sync1 = {i_intf_strap_hi, i_intf_strap_lo, i_e, i_reg_select, i_rw, i_db};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1_ff <= 13'h0000;
      sync2_ff <= 13'h0000;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // Interface select from straps
  always_comb begin
    e_s = sync2_ff[10];
    sel_s = sync2_ff[9];
    rw_s = sync2_ff[8];
    db_s = sync2_ff[7:0];
    if (sync2_ff[12]) begin
      mode = CLHI_SPI;
    end else if (sync2_ff[11]) begin
      mode = CLHI_I2C;
    end else begin
      mode = CLHI_PAR;
    end
  end

  // ==========================================================
  // Serial front ends
  clhi_byte_if spi_byte ();
  clhi_byte_if i2c_byte ();
  logic sda_pull;  // I2C acknowledge drive

  clhi_spi_rx u_spi (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(mode == CLHI_SPI),
    .i_cs_n(db_s[5]),
    .i_sclk(db_s[6]),
    .i_serial_in(db_s[7]),
    .i_reg_select(sel_s),
    .o_byte(spi_byte)
  );

  clhi_i2c_rx u_i2c (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(mode == CLHI_I2C),
    .i_scl(db_s[7]),
    .i_sda(db_s[6]),
    .i_addr_strap(db_s[1:0]),
    .o_sda_pull(sda_pull),
    .o_byte(i2c_byte)
  );

  // ==========================================================
  // Instruction state
  logic [6:0] addr_counter_ff, nxt_addr_counter;  // Address counter
  logic glyph_ff, nxt_glyph;  // Glyph RAM targeted
  logic inc_ff, nxt_inc;  // Entry direction
  logic bus8_ff, nxt_bus8;  // Width bit
  logic two_ff, nxt_two;  // Two-line mode
  logic [9:0] busy_cnt_ff, nxt_busy_cnt;  // Execution countdown
  logic [7:0] rd_latch_ff, nxt_rd_latch;  // Prefetched read byte
  logic e_d_ff, nxt_e_d;  // Previous strobe
  logic nib_ff, nxt_nib;  // Low nibble expected
  logic [3:0] hi_nib_ff, nxt_hi_nib;  // Stored high nibble
  logic [7:0] dout_ff, nxt_dout;  // Pin data out
  logic [7:0] doe_ff, nxt_doe;  // Pin enables
  logic [7:0] text_ram [0:127];  // Text RAM
  logic [7:0] glyph_ram [0:63];  // Glyph RAM
  logic req_vld, req_data;  // Executed byte strobe and kind
  logic [7:0] req_byte;  // Executed byte
  logic rd_step;  // Parallel data read completed
  logic ram_we, do_pf;  // RAM write, prefetch
  logic busy;
  logic [7:0] status;

  // Address step with line wrap
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                           input logic gl, input logic two);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (gl) begin
      r[6] = 1'h0;
    end else if (!two) begin
      if (up && a == TXT_1L_LAST) begin
        r = 7'h00;
      end else if (!up && a == 7'h00) begin
        r = TXT_1L_LAST;
      end
    end else begin
      if (up && a == TXT_L1_LAST) begin
        r = TXT_L2_FIRST;
      end else if (up && a == TXT_L2_LAST) begin
        r = 7'h00;
      end else if (!up && a == TXT_L2_FIRST) begin
        r = TXT_L1_LAST;
      end else if (!up && a == 7'h00) begin
        r = TXT_L2_LAST;
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Parallel port strobes and byte source
  always_comb begin
    busy = (busy_cnt_ff != 10'h000);
    status = {busy, addr_counter_ff};
    nxt_e_d = e_s;
    nxt_nib = nib_ff;
    nxt_hi_nib = hi_nib_ff;
    req_vld = 1'h0;
    req_data = sel_s;
    req_byte = db_s;
    rd_step = 1'h0;
    case (mode)
      CLHI_PAR: begin
        if (e_d_ff && !e_s) begin
          // Falling strobe completes a transfer
          if (bus8_ff) begin
            nxt_nib = 1'h0;
            req_vld = !rw_s;
            rd_step = rw_s && sel_s;
          end else if (!nib_ff) begin
            nxt_nib = 1'h1;
            nxt_hi_nib = db_s[7:4];
          end else begin
            nxt_nib = 1'h0;
            req_vld = !rw_s;
            req_byte = {hi_nib_ff, db_s[7:4]};
            rd_step = rw_s && sel_s;
          end
        end
      end
      CLHI_SPI: begin
        req_vld = spi_byte.valid;
        req_data = spi_byte.is_data;
        req_byte = spi_byte.data;
      end
      CLHI_I2C: begin
        req_vld = i2c_byte.valid;
        req_data = i2c_byte.is_data;
        req_byte = i2c_byte.data;
      end
      default: ;
    endcase
  end

  // Read drive on the data pins
  always_comb begin
    nxt_dout = 8'h00;
    nxt_doe = 8'h00;
    if (mode == CLHI_PAR && rw_s && e_s) begin
      nxt_dout = sel_s ? rd_latch_ff : status;
      nxt_doe = 8'hFF;
      if (!bus8_ff) begin
        nxt_dout = nib_ff ? {nxt_dout[3:0], 4'h0} : {nxt_dout[7:4], 4'h0};
        nxt_doe = 8'hF0;
      end
    end
  end

  // ==========================================================
  // Instruction and data execution
  always_comb begin
    nxt_addr_counter = addr_counter_ff;
    nxt_glyph = glyph_ff;
    nxt_inc = inc_ff;
    nxt_bus8 = bus8_ff;
    nxt_two = two_ff;
    nxt_busy_cnt = busy ? busy_cnt_ff - 10'h001 : busy_cnt_ff;
    nxt_rd_latch = rd_latch_ff;
    ram_we = 1'h0;
    do_pf = 1'h0;
    if (req_vld) begin
      nxt_busy_cnt = EXEC_CNT;
      if (req_data) begin
        ram_we = 1'h1;
        nxt_addr_counter = step_addr(addr_counter_ff, inc_ff, glyph_ff, two_ff);
      end else if (req_byte[7]) begin
        nxt_addr_counter = req_byte[6:0];
        nxt_glyph = 1'h0;
        do_pf = 1'h1;
      end else if (req_byte[7:6] == 2'h1) begin
        nxt_addr_counter = {1'h0, req_byte[5:0]};
        nxt_glyph = 1'h1;
        do_pf = 1'h1;
      end else if (req_byte[7:5] == 3'h1) begin
        nxt_bus8 = req_byte[FS_WIDTH_POS];
        nxt_two = req_byte[FS_LINES_POS];
      end else if (req_byte[7:4] == 4'h1) begin
        // Display shift itself is not modelled here
        if (!req_byte[SH_DISP_POS]) begin
          nxt_addr_counter = step_addr(addr_counter_ff, req_byte[SH_RIGHT_POS],
                                       glyph_ff, two_ff);
          do_pf = !glyph_ff;
        end
      end else if (req_byte[7:2] == 6'h01) begin
        nxt_inc = req_byte[EM_INC_POS];
      end
    end else if (rd_step) begin
      nxt_addr_counter = step_addr(addr_counter_ff, inc_ff, glyph_ff, two_ff);
      do_pf = 1'h1;
    end
    // RAM data writes leave the prefetched byte alone
    if (do_pf) begin
      nxt_rd_latch = nxt_glyph ? glyph_ram[nxt_addr_counter[5:0]]
                               : text_ram[nxt_addr_counter];
    end
  end

  // RAM write port
  always_ff @(posedge i_clk) begin
    if (ram_we && glyph_ff) begin
      glyph_ram[addr_counter_ff[5:0]] <= req_byte;
    end
    if (ram_we && !glyph_ff) begin
      text_ram[addr_counter_ff] <= req_byte;
    end
  end

  // State registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      addr_counter_ff <= 7'h00;
      glyph_ff <= 1'h0;
      inc_ff <= RST_INC;
      bus8_ff <= RST_BUS8;
      two_ff <= RST_TWO_LINE;
      busy_cnt_ff <= 10'h000;
      rd_latch_ff <= 8'h00;
      e_d_ff <= 1'h0;
      nib_ff <= 1'h0;
      hi_nib_ff <= 4'h0;
      dout_ff <= 8'h00;
      doe_ff <= 8'h00;
    end else begin
      addr_counter_ff <= nxt_addr_counter;
      glyph_ff <= nxt_glyph;
      inc_ff <= nxt_inc;
      bus8_ff <= nxt_bus8;
      two_ff <= nxt_two;
      busy_cnt_ff <= nxt_busy_cnt;
      rd_latch_ff <= nxt_rd_latch;
      e_d_ff <= nxt_e_d;
      nib_ff <= nxt_nib;
      hi_nib_ff <= nxt_hi_nib;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
    end
  end

  // ==========================================================
  // Outputs
  assign o_db = dout_ff;
  assign o_db_oe = doe_ff | {1'h0, sda_pull, 6'h00};
  assign o_busy_indicator = busy;
  assign o_addr_counter = addr_counter_ff;
  assign o_glyph_sel = glyph_ff;
  assign o_entry_inc = inc_ff;
  assign o_bus_8bit = bus8_ff;
  assign o_two_line = two_ff;
endmodule
`default_nettype wire

// *** pkg/clhi_pkg.sv ***
`default_nettype none
package clhi_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_FREQ_MHZ = 50;  // Core clock rate
  localparam int EXEC_TIME_NS = 18500;  // Execution time of one instruction
  localparam int EXEC_CYC = (EXEC_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam logic [9:0] EXEC_CNT = 10'(EXEC_CYC);  // Busy cycles per byte
  // ==========================================================
  // Instruction fields
  localparam int FS_WIDTH_POS = 4;  // Function set: bus width
  localparam int FS_LINES_POS = 3;  // Function set: two-line mode
  localparam int SH_DISP_POS = 3;  // Shift: display instead of cursor
  localparam int SH_RIGHT_POS = 2;  // Shift: to the right
  localparam int EM_INC_POS = 1;  // Entry mode: increment
  // ==========================================================
  // Text RAM address limits
  localparam logic [6:0] TXT_1L_LAST = 7'h4F;
  localparam logic [6:0] TXT_L1_LAST = 7'h27;
  localparam logic [6:0] TXT_L2_FIRST = 7'h40;
  localparam logic [6:0] TXT_L2_LAST = 7'h67;
  // ==========================================================
  // Reset values and serial constants
  localparam logic RST_INC = 1'h1;  // Increment after reset
  localparam logic RST_BUS8 = 1'h1;  // 8-bit bus after reset
  localparam logic RST_TWO_LINE = 1'h0;  // One line after reset
  localparam logic [4:0] I2C_ADDR_HI = 5'h0F;  // Upper five address bits
  localparam logic [2:0] BIT_LAST = 3'h7;  // Last bit index of a byte
  // ==========================================================
  // Types
  typedef enum logic [1:0] {CLHI_PAR, CLHI_I2C, CLHI_SPI} clhi_mode_t;
  typedef enum logic [1:0] {I2_IDLE, I2_RECV, I2_ACK, I2_SKIP} clhi_i2c_st_t;
  typedef enum logic [1:0] {K_ADDR, K_CTRL, K_DATA} clhi_kind_t;
endpackage
`default_nettype wire

// *** pkg/clhi_byte_if.sv ***
`default_nettype none
// ==========================================================
// Received byte from a serial front end
interface clhi_byte_if;
  logic valid;  // One-cycle byte strobe
  logic is_data;  // High for RAM data, low for instruction
  logic [7:0] data;  // Received byte
  modport src(output valid, output is_data, output data);
  modport dst(input valid, input is_data, input data);
endinterface
`default_nettype wire

// *** design/clhi_spi_rx.sv ***
`default_nettype none
module clhi_spi_rx
  import clhi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_serial_in,
  input wire logic i_reg_select,
  clhi_byte_if.src o_byte
);
  // ==========================================================
  // State
  logic sclk_d_ff, nxt_sclk_d;  // Previous serial clock
  logic [2:0] cnt_ff, nxt_cnt;  // Bit count
  logic [6:0] shift_ff, nxt_shift;  // Shift register
  logic vld_ff, nxt_vld;  // Byte strobe
  logic sel_ff, nxt_sel;  // Data or instruction
  logic [7:0] data_ff, nxt_data;  // Byte out

  // Shift on rising clock, MSB first
  always_comb begin
    nxt_sclk_d = i_sclk;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_vld = 1'h0;
    nxt_sel = sel_ff;
    nxt_data = data_ff;
    if (!i_en || i_cs_n) begin
      nxt_cnt = 3'h0;
    end else if (i_sclk && !sclk_d_ff) begin
      nxt_shift = {shift_ff[5:0], i_serial_in};
      nxt_cnt = cnt_ff + 3'h1;
      if (cnt_ff == BIT_LAST) begin
        nxt_vld = 1'h1;
        nxt_data = {shift_ff, i_serial_in};
        nxt_sel = i_reg_select;
      end
    end
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sclk_d_ff <= 1'h1;
      cnt_ff <= 3'h0;
      shift_ff <= 7'h00;
      vld_ff <= 1'h0;
      sel_ff <= 1'h0;
      data_ff <= 8'h00;
    end else begin
      sclk_d_ff <= nxt_sclk_d;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      vld_ff <= nxt_vld;
      sel_ff <= nxt_sel;
      data_ff <= nxt_data;
    end
  end

  assign o_byte.valid = vld_ff;
  assign o_byte.is_data = sel_ff;
  assign o_byte.data = data_ff;
endmodule
`default_nettype wire

// *** design/clhi_i2c_rx.sv ***
`default_nettype none
module clhi_i2c_rx
  import clhi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [1:0] i_addr_strap,
  output logic o_sda_pull,
  clhi_byte_if.src o_byte
);
  // ==========================================================
  // State
  clhi_i2c_st_t st_ff, nxt_st;  // Receiver state
  clhi_kind_t kind_ff, nxt_kind;  // Meaning of the next byte
  logic scl_d_ff, nxt_scl_d;  // Previous SCL
  logic sda_d_ff, nxt_sda_d;  // Previous SDA
  logic [3:0] cnt_ff, nxt_cnt;  // Bits received
  logic [7:0] shift_ff, nxt_shift;  // Shift register
  logic continue_ff, nxt_continue;  // Control bytes still to come
  logic cmd_data_sel_ff, nxt_cmd_data_sel;  // Data or command
  logic vld_ff, nxt_vld;
  logic [7:0] data_ff, nxt_data;
  logic start_c, stop_c, scl_rise, scl_fall;

  // Bus conditions and receive sequence
  always_comb begin
    start_c = scl_d_ff && i_scl && sda_d_ff && !i_sda;
    stop_c = scl_d_ff && i_scl && !sda_d_ff && i_sda;
    scl_rise = i_scl && !scl_d_ff;
    scl_fall = !i_scl && scl_d_ff;
    nxt_scl_d = i_scl;
    nxt_sda_d = i_sda;
    nxt_st = st_ff;
    nxt_kind = kind_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_continue = continue_ff;
    nxt_cmd_data_sel = cmd_data_sel_ff;
    nxt_vld = 1'h0;
    nxt_data = data_ff;
    if (!i_en || stop_c) begin
      nxt_st = I2_IDLE;
    end else if (start_c) begin
      nxt_st = I2_RECV;
      nxt_kind = K_ADDR;
      nxt_cnt = 4'h0;
    end else begin
      case (st_ff)
        I2_RECV: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], i_sda};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == 4'h8) begin
            nxt_st = I2_ACK;
            case (kind_ff)
              K_ADDR: begin
                // Own address, write direction only
                if (shift_ff[7:1] != {I2C_ADDR_HI, i_addr_strap} || shift_ff[0]) begin
                  nxt_st = I2_SKIP;
                end
                nxt_kind = K_CTRL;
              end
              K_CTRL: begin
                nxt_continue = shift_ff[7];
                nxt_cmd_data_sel = shift_ff[6];
                nxt_kind = K_DATA;
              end
              default: begin
                nxt_vld = 1'h1;
                nxt_data = shift_ff;
                nxt_kind = continue_ff ? K_CTRL : K_DATA;
              end
            endcase
          end
        end
        I2_ACK: begin
          if (scl_fall) begin
            nxt_st = I2_RECV;  // Release after the acknowledge clock
            nxt_cnt = 4'h0;
          end
        end
        default: ;  // Idle or not addressed
      endcase
    end
  end

  // Registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff <= I2_IDLE;
      kind_ff <= K_ADDR;
      scl_d_ff <= 1'h1;
      sda_d_ff <= 1'h1;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      continue_ff <= 1'h0;
      cmd_data_sel_ff <= 1'h0;
      vld_ff <= 1'h0;
      data_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      kind_ff <= nxt_kind;
      scl_d_ff <= nxt_scl_d;
      sda_d_ff <= nxt_sda_d;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      continue_ff <= nxt_continue;
      cmd_data_sel_ff <= nxt_cmd_data_sel;
      vld_ff <= nxt_vld;
      data_ff <= nxt_data;
    end
  end

  assign o_sda_pull = (st_ff == I2_ACK);
  assign o_byte.valid = vld_ff;
  assign o_byte.is_data = cmd_data_sel_ff;
  assign o_byte.data = data_ff;
endmodule
`default_nettype wire

// *** tb/clhi_checker.sv ***
`default_nettype none
module clhi_checker
  import clhi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_e,
  input wire logic i_reg_select,
  input wire logic i_rw,
  input wire logic [7:0] i_db,
  input wire logic i_intf_strap_hi,
  input wire logic i_intf_strap_lo,
  input wire logic [7:0] o_db,
  input wire logic [7:0] o_db_oe,
  input wire logic o_busy_indicator,
  input wire logic [6:0] o_addr_counter,
  input wire logic o_glyph_sel,
  input wire logic o_entry_inc,
  input wire logic o_bus_8bit,
  input wire logic o_two_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Busy length counter
  logic [9:0] cnt_ff;  // Busy cycles so far
  logic [9:0] nxt_cnt;  // Next count
  // Count while busy, clear when idle
  always_comb begin
    nxt_cnt = o_busy_indicator ? cnt_ff + 10'h001 : 10'h000;
  end
  always_ff @(posedge i_clk) begin
    cnt_ff <= nxt_cnt;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic par = !i_intf_strap_hi && !i_intf_strap_lo;  // Parallel bus chosen
  AST_RST_VALS: assert property (disable iff (1'b0) !i_rst_n |=>
    o_addr_counter == 7'h00 && o_entry_inc && o_bus_8bit && !o_two_line && !o_glyph_sel
    && !o_busy_indicator && o_db_oe == 8'h00) else $error("reset values wrong");
  AST_BUSY_LEN: assert property ($fell(o_busy_indicator) |-> cnt_ff == EXEC_CNT)
    else $error("busy length wrong");
  AST_OE_SPI: assert property (i_intf_strap_hi && $past(i_intf_strap_hi, 4)
    |-> o_db_oe == 8'h00) else $error("drive in serial mode");
  AST_OE_WIDTH: assert property (par && $past(par, 4) && o_db_oe != 8'h00
    |-> o_db_oe == (o_bus_8bit ? 8'hFF : 8'hF0)) else $error("read drive width wrong");
  AST_I2C_OE: assert property (!i_intf_strap_hi && i_intf_strap_lo
    && $past(i_intf_strap_lo, 4) |-> (o_db_oe & 8'hBF) == 8'h00 && !(o_db_oe[6] && o_db[6]))
    else $error("i2c drive wrong");
  AST_GLYPH_RANGE: assert property (o_glyph_sel |-> !o_addr_counter[6])
    else $error("glyph address too wide");
  AST_ONE_LINE: assert property (!o_glyph_sel && !o_two_line |-> o_addr_counter <= 7'h4F)
    else $error("one-line address out of range");
  AST_TWO_LINE: assert property (!o_glyph_sel && o_two_line |-> o_addr_counter <= 7'h27
    || (o_addr_counter >= 7'h40 && o_addr_counter <= 7'h67)) else $error("two-line address wrong");
  cover property ($rose(o_busy_indicator));
  cover property (o_db_oe == 8'hF0);
  cover property (o_db_oe[6] && i_intf_strap_lo);
endmodule
`default_nettype wire

// *** tb/clhi_host_model.sv ***
`default_nettype none
module clhi_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_db,
  input wire logic [7:0] i_db_oe,
  output logic o_e,
  output logic o_rs,
  output logic o_rw,
  output logic [7:0] o_db
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hd = 8'h00;  // Host pin values
  logic hoe = 1'b1;  // Host drives the pins
  logic junk = 1'b0;  // Toggles so floating pins never hold
  initial begin
    o_e = 1'b0;
    o_rs = 1'b0;
    o_rw = 1'b0;
  end
  always @(posedge i_clk) junk <= ~junk;
  // Wire level: open-drain pull wins over host, else device drive or junk
  assign o_db = hoe ? (hd & ~(i_db_oe & ~i_db)) : ((i_db & i_db_oe) | ({8{junk}} & ~i_db_oe));
  // ==========================================================
  // One parallel strobe, returns the pins while strobe is high
  task automatic par(input logic r, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk);
    o_rs = r;
    o_rw = w;
    hd = d;
    hoe = !w;
    @(negedge i_clk);
    o_e = 1'b1;
    repeat (6) @(negedge i_clk);
    q = o_db;
    o_e = 1'b0;
    repeat (6) @(negedge i_clk);
    hoe = 1'b1;
  endtask
  // SPI frame: clock idles high, data held while low, MSB first
  task automatic spi(input logic r, input logic [7:0] d);
    @(negedge i_clk);
    o_rs = r;
    hd = 8'h40;
    repeat (4) @(negedge i_clk);
    for (int i = 7; i >= 0; i--) begin
      hd[6] = 1'b0;
      hd[7] = d[i];
      repeat (4) @(negedge i_clk);
      hd[6] = 1'b1;
      repeat (4) @(negedge i_clk);
    end
    hd[5] = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
  // I2C start and stop with SCL high
  task automatic i2c_cond(input logic stop);
    hd[6] = stop ? 1'b0 : 1'b1;
    repeat (4) @(negedge i_clk);
    hd[7] = 1'b1;
    repeat (4) @(negedge i_clk);
    hd[6] = stop;
    repeat (4) @(negedge i_clk);
    hd[7] = stop;
    repeat (4) @(negedge i_clk);
  endtask
  // I2C byte, then releases SDA and samples the acknowledge
  task automatic i2c_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      hd[6] = d[i];
      repeat (4) @(negedge i_clk);
      hd[7] = 1'b1;
      repeat (4) @(negedge i_clk);
      hd[7] = 1'b0;
    end
    hd[6] = 1'b1;
    repeat (4) @(negedge i_clk);
    hd[7] = 1'b1;
    repeat (2) @(negedge i_clk);
    ack = !o_db[6];
    repeat (2) @(negedge i_clk);
    hd[7] = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;  // Core clock
  logic rst_n = 1'b0;  // Reset, active low
  logic s_hi = 1'b0;  // SPI strap
  logic s_lo = 1'b0;  // I2C strap
  logic e, rs, rw, busy, gl, inc, b8, two, ack;
  logic [7:0] pin, d_out, d_oe, rd;
  logic [6:0] ac;
  int err_count = 0;
  int check_count = 0;
  initial forever #10 clk = ~clk;
  clhi_host_model host (.i_clk(clk), .i_db(d_out), .i_db_oe(d_oe), .o_e(e), .o_rs(rs),
    .o_rw(rw), .o_db(pin));
  clhi_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_e(e), .i_reg_select(rs), .i_rw(rw),
    .i_db(pin), .i_intf_strap_hi(s_hi), .i_intf_strap_lo(s_lo), .o_db(d_out), .o_db_oe(d_oe),
    .o_busy_indicator(busy), .o_addr_counter(ac), .o_glyph_sel(gl), .o_entry_inc(inc),
    .o_bus_8bit(b8), .o_two_line(two));
  // ==========================================================
  // Helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Bounded wait until not busy, then a spare cycle
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n < 2000) @(negedge clk);
    else begin
      chk("busy_wait", 8'h00, {7'h00, busy});
      end_sim();
    end
  endtask
  task automatic wr(input logic r, input logic [7:0] d);
    host.par(r, 1'b0, d, rd);
    idle();
  endtask
  task automatic rdd(input logic r);
    host.par(r, 1'b1, 8'h00, rd);
    idle();
  endtask
  task automatic do_rst(input logic hi, input logic lo, input logic [7:0] pins);
    @(negedge clk);
    rst_n = 1'b0;
    s_hi = hi;
    s_lo = lo;
    host.hd = pins;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    do_rst(1'b0, 1'b0, 8'h00);
    chk("rst_state", 8'h00, {gl, ac});
    chk("rst_flags", 8'h06, {4'h0, gl, inc, b8, two});
    wr(1'b0, 8'h90);
    chk("ac_text", 8'h10, {gl, ac});
    wr(1'b1, 8'hA5);
    chk("ac_step", 8'h11, {gl, ac});
    wr(1'b1, 8'h3C);
    wr(1'b0, 8'h90);
    rdd(1'b1);
    chk("rd0", 8'hA5, rd);
    chk("ac_rd", 8'h11, {gl, ac});
    rdd(1'b1);
    chk("rd1", 8'h3C, rd);
    wr(1'b0, 8'hA0);
    wr(1'b1, 8'h11);
    wr(1'b1, 8'h22);
    wr(1'b0, 8'hA0);
    wr(1'b1, 8'h99);
    rdd(1'b1);
    chk("rd_prefetch", 8'h11, rd);
    host.par(1'b1, 1'b0, 8'h55, rd);
    rdd(1'b0);
    chk("status_busy", 8'hA3, rd);
    $display("test text done");
    wr(1'b0, 8'h45);
    chk("ac_glyph", 8'h85, {gl, ac});
    wr(1'b1, 8'h1F);
    wr(1'b0, 8'h45);
    rdd(1'b1);
    chk("rd_glyph", 8'h1F, rd);
    wr(1'b0, 8'hCF);
    wr(1'b1, 8'h00);
    chk("wrap_one", 8'h00, {gl, ac});
    wr(1'b0, 8'h38);
    chk("two_line", 8'h03, {6'h00, b8, two});
    wr(1'b0, 8'hA7);
    wr(1'b1, 8'h00);
    chk("wrap_two", 8'h40, {gl, ac});
    wr(1'b0, 8'h04);
    wr(1'b1, 8'h00);
    chk("ac_dec", 8'h27, {inc, ac});
    $display("test wrap done");
    wr(1'b0, 8'h28);
    chk("bus4", 8'h01, {6'h00, b8, two});
    host.par(1'b0, 1'b0, 8'h80, rd);
    chk("busy_nib1", 8'h00, {7'h00, busy});
    host.par(1'b0, 1'b0, 8'h50, rd);
    chk("busy_nib2", 8'h01, {7'h00, busy});
    idle();
    chk("ac_4bit", 8'h05, {gl, ac});
    rdd(1'b0);
    chk("st_hi", 8'h00, {4'h0, rd[7:4]});
    rdd(1'b0);
    chk("st_lo", 8'h05, {4'h0, rd[7:4]});
    $display("test nibble done");
    do_rst(1'b1, 1'b0, 8'h60);
    host.spi(1'b0, 8'hB3);
    idle();
    chk("spi_addr", 8'h33, {gl, ac});
    host.spi(1'b1, 8'h66);
    idle();
    chk("spi_data", 8'h34, {gl, ac});
    $display("test spi done");
    do_rst(1'b0, 1'b1, 8'hC0);
    host.i2c_cond(1'b0);
    host.i2c_byte(8'h7A, ack);
    chk("ack_other", 8'h00, {7'h00, ack});
    host.i2c_cond(1'b1);
    host.i2c_cond(1'b0);
    host.i2c_byte(8'h78, ack);
    chk("ack_addr", 8'h01, {7'h00, ack});
    host.i2c_byte(8'h00, ack);
    chk("ack_ctrl", 8'h01, {7'h00, ack});
    host.i2c_byte(8'h92, ack);
    chk("ack_data", 8'h01, {7'h00, ack});
    host.i2c_cond(1'b1);
    idle();
    chk("i2c_addr", 8'h12, {gl, ac});
    $display("test i2c done");
    end_sim();
  end
endmodule
bind clhi_top clhi_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_e(i_e),
  .i_reg_select(i_reg_select), .i_rw(i_rw), .i_db(i_db), .i_intf_strap_hi(i_intf_strap_hi),
  .i_intf_strap_lo(i_intf_strap_lo), .o_db(o_db), .o_db_oe(o_db_oe),
  .o_busy_indicator(o_busy_indicator), .o_addr_counter(o_addr_counter),
  .o_glyph_sel(o_glyph_sel), .o_entry_inc(o_entry_inc), .o_bus_8bit(o_bus_8bit),
  .o_two_line(o_two_line));
`default_nettype wire
